// ==== core/hbd_pkg.sv ====
package hbd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing.

	// System clock period in nanoseconds.
	localparam int CLK_NS = 10;
	// Least off time of a leg between a low and a high drive, in ns.
	localparam int DEAD_NS = 200;
	// Brake time that the controller inserts before a reversal, in ns.
	localparam int BRAKE_NS = 1000;
	// Time that the logic supply is held off for a restart, in ns.
	localparam int PWR_OFF_NS = 1000;
	// Least times round up to whole cycles.
	localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int BRAKE_CYC = (BRAKE_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWR_OFF_CYC = (PWR_OFF_NS + CLK_NS - 1) / CLK_NS;
	localparam int DEAD_W = $clog2(DEAD_CYC + 1);
	localparam int BRAKE_W = $clog2(BRAKE_CYC + 1);
	localparam int PWR_W = $clog2(PWR_OFF_CYC + 1);

	////////////////////////////////////////////////////////////////////////
	// Controller register map.

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PWM = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;

	// Control register fields.
	localparam int CTRL_W = 11;
	localparam int CTRL_CFG_A = 0;
	localparam int CTRL_CFG_B = 1;
	localparam int CTRL_SLEEP_N = 2;
	localparam int CTRL_DIAG = 3;
	localparam int CTRL_PWR = 4;
	localparam int CTRL_EN1 = 5;
	localparam int CTRL_EN2 = 6;
	localparam int CTRL_INH1 = 7;
	localparam int CTRL_INH2 = 8;
	localparam int CTRL_HS1 = 9;
	localparam int CTRL_HS2 = 10;
	localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

	// Drive register fields.
	localparam int PWMR_W = 12;
	localparam int PWM_REQ_LSB = 0;
	localparam int PWM_FLT_LSB = 4;
	localparam int EN_FLT_LSB = 8;
	localparam int INH_FLT_LSB = 10;
	localparam logic [PWMR_W-1:0] PWMR_RST = 12'h000;

	// Status register fields.
	localparam int STAT_LVL_LSB = 0;
	localparam int STAT_OE_LSB = 4;
	localparam int STAT_PWR_OFF = 8;
	localparam int STAT_BRK_LSB = 9;

	////////////////////////////////////////////////////////////////////////
	// Types.

	typedef enum logic [1:0] {
		MODE_COMBINED,
		MODE_DUAL,
		MODE_HALF,
		MODE_PROHIBITED
	} hbd_mode_t;

	typedef enum logic [1:0] {
		LEG_OFF,
		LEG_LO,
		LEG_HI
	} hbd_leg_t;

	typedef struct packed {
		logic cfg_valid;
		hbd_mode_t mode;
		hbd_leg_t [3:0] leg;
		logic [3:0][DEAD_W-1:0] dead;
		logic [3:0] lvl;
		logic [3:0] oe;
	} hbd_dev_st_t;

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [PWMR_W-1:0] drv;
		logic [3:0] pwm_app;
		logic [1:0][BRAKE_W-1:0] brake;
		logic [PWR_W-1:0] pwr_cnt;
		logic diag;
		logic [31:0] rdata;
		logic [3:0] pwm_oe;
		logic [1:0] en_lvl;
		logic [1:0] en_oe;
		logic [1:0] inh_lvl;
		logic [1:0] inh_oe;
		logic [1:0] host_sel;
		logic sleep_n;
		logic cfg_a;
		logic cfg_b;
		logic supply_on;
	} hbd_host_st_t;

	// Both state records clear to all zeros.
	localparam hbd_dev_st_t DEV_RST = '0;
	localparam hbd_host_st_t HOST_RST = '0;

endpackage : hbd_pkg

// ==== core/hbd_if.sv ====
// Pin bundle between the controller and the bridge driver.
interface hbd_if;
	// Controller to driver; each *_oe is high while the pin is driven.
	logic pwm_in_a;
	logic pwm_in_b;
	logic pwm_in_c;
	logic pwm_in_d;
	logic pwm_oe_a;
	logic pwm_oe_b;
	logic pwm_oe_c;
	logic pwm_oe_d;
	logic drive_enable_first;
	logic drive_enable_second;
	logic drive_enable_first_oe;
	logic drive_enable_second_oe;
	logic channel_inhibit_first;
	logic channel_inhibit_second;
	logic channel_inhibit_first_oe;
	logic channel_inhibit_second_oe;
	logic low_power_request_n;
	logic bridge_config_sel_a;
	logic bridge_config_sel_b;
	logic host_select_first;
	logic host_select_second;
	logic supply_on;
	logic diag_start;
	// Driver to motor; each *_oe is high while the leg drives.
	logic bridge_out_a;
	logic bridge_out_b;
	logic bridge_out_c;
	logic bridge_out_d;
	logic bridge_oe_a;
	logic bridge_oe_b;
	logic bridge_oe_c;
	logic bridge_oe_d;

	modport dev (
		input pwm_in_a, pwm_in_b, pwm_in_c, pwm_in_d,
		input pwm_oe_a, pwm_oe_b, pwm_oe_c, pwm_oe_d,
		input drive_enable_first, drive_enable_second,
		input drive_enable_first_oe, drive_enable_second_oe,
		input channel_inhibit_first, channel_inhibit_second,
		input channel_inhibit_first_oe, channel_inhibit_second_oe,
		input low_power_request_n, bridge_config_sel_a, bridge_config_sel_b,
		input host_select_first, host_select_second, supply_on, diag_start,
		output bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d,
		output bridge_oe_a, bridge_oe_b, bridge_oe_c, bridge_oe_d
	);

	modport host (
		output pwm_in_a, pwm_in_b, pwm_in_c, pwm_in_d,
		output pwm_oe_a, pwm_oe_b, pwm_oe_c, pwm_oe_d,
		output drive_enable_first, drive_enable_second,
		output drive_enable_first_oe, drive_enable_second_oe,
		output channel_inhibit_first, channel_inhibit_second,
		output channel_inhibit_first_oe, channel_inhibit_second_oe,
		output low_power_request_n, bridge_config_sel_a, bridge_config_sel_b,
		output host_select_first, host_select_second, supply_on, diag_start,
		input bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d,
		input bridge_oe_a, bridge_oe_b, bridge_oe_c, bridge_oe_d
	);
endinterface : hbd_if

// ==== core/hbd_device.sv ====
// Operation
// - Both selects low: one combined wide bridge.
// - Select B high only: two separate bridges.
// - Select A only half mode; both: outputs off.
// - Selects captured once when diagnosis starts.
// - Prohibited state ends only by supply reset.
// - Dual mode: outputs follow inputs, equal means brake.
// - Enable low, inhibit high or floating: outputs off.
// - Floating pwm input reads as low.
// - Sleep request low forces every output off.
// - Sleep request high resumes normal output control.
// - Controller drives inhibits firmly while requesting sleep.
// - Combined mode: pwm A, B drive paired outputs.
// - Controller ties second channel pins to first.
// - Half mode: each output follows own pwm.
// - Half mode ignores the serial drive path.
// - Controller keeps first host select low in half.
// - Half mode with first host select high: off.
// - That off state clears when select returns low.
// - Controller brakes between forward and reverse.
// - Current chopping may override the decoded outputs.
// - Host select picks pwm pins or serial path.
module hbd_device
	import hbd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	hbd_if.dev pins,
	input wire logic [3:0] serial_level,
	input wire logic [3:0] serial_drive,
	input wire logic [1:0] chop_active,
	output logic cfg_latched,
	output hbd_mode_t cfg_mode
);

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Turns a drive request and a level into a leg state.
	function automatic hbd_leg_t to_leg(input logic drive, input logic level);
		hbd_leg_t r;
		r = LEG_OFF;
		if (drive) begin
			r = level ? LEG_HI : LEG_LO;
		end
		return r;
	endfunction : to_leg

	// Maps the two configuration straps onto a bridge mode.
	// All four codes are legal: prohibited is a mode of its own and not an
	// error, so the case needs no default.
	function automatic hbd_mode_t decode_mode(input logic sa, input logic sb);
		hbd_mode_t m;
		unique case ({sa, sb})
			2'b00: m = MODE_COMBINED;
			2'b01: m = MODE_DUAL;
			2'b10: m = MODE_HALF;
			2'b11: m = MODE_PROHIBITED;
		endcase
		return m;
	endfunction : decode_mode

	////////////////////////////////////////////////////////////////////////
	// State.

	hbd_dev_st_t st_q;
	hbd_dev_st_t st_d;

	////////////////////////////////////////////////////////////////////////
	// Next state.

	// Pin decode, gating and dead time all work on the registered mode.
	// A pin that is not driven reads as its pull level: pwm and enable pull
	// low, the inhibit counts as asserted; host select and sleep request have no output enable.
	always_comb begin
		logic [3:0] pwm;
		logic [1:0] en_ok;
		logic [1:0] inh_ok;
		logic [1:0] host_sel;
		logic awake;
		logic src;
		logic ch;
		hbd_leg_t tgt;
		pwm = '0;
		en_ok = '0;
		inh_ok = '0;
		host_sel = '0;
		awake = 1'b0;
		src = 1'b0;
		ch = 1'b0;
		tgt = LEG_OFF;
		st_d = st_q;
		// An undriven pwm input counts as low.
		pwm[0] = pins.pwm_oe_a & pins.pwm_in_a;
		pwm[1] = pins.pwm_oe_b & pins.pwm_in_b;
		pwm[2] = pins.pwm_oe_c & pins.pwm_in_c;
		pwm[3] = pins.pwm_oe_d & pins.pwm_in_d;
		// Floating enable or inhibit disables the channel.
		en_ok[0] = pins.drive_enable_first_oe & pins.drive_enable_first;
		en_ok[1] = pins.drive_enable_second_oe & pins.drive_enable_second;
		inh_ok[0] = pins.channel_inhibit_first_oe &
			~pins.channel_inhibit_first;
		inh_ok[1] = pins.channel_inhibit_second_oe &
			~pins.channel_inhibit_second;
		host_sel[0] = pins.host_select_first;
		host_sel[1] = pins.host_select_second;
		awake = pins.low_power_request_n;

		// The straps are caught once; later changes are not seen.
		if (!st_q.cfg_valid && pins.diag_start) begin
			st_d.cfg_valid = 1'b1;
			st_d.mode = decode_mode(pins.bridge_config_sel_a,
				pins.bridge_config_sel_b);
		end

		for (int i = 0; i < 4; i++) begin
			// Combined mode steers legs a, b from pwm A and c, d from pwm B,
			// and takes channel control from the first channel's pins.
			if (st_q.mode == MODE_COMBINED) begin
				src = pwm[i >> 1];
				ch = 1'b0;
			end else begin
				src = pwm[i];
				ch = (i >= 2);
			end
			// Off conditions in falling priority, then the decode.
			if (!st_q.cfg_valid || st_q.mode == MODE_PROHIBITED) begin
				tgt = LEG_OFF;
			end else if (!awake) begin
				tgt = LEG_OFF;
			end else if (!en_ok[ch] || !inh_ok[ch]) begin
				tgt = LEG_OFF;
			end else if (st_q.mode == MODE_HALF) begin
				// Serial drive is unused here; only the pins count.
				if (host_sel[0]) begin
					tgt = LEG_OFF;
				end else begin
					tgt = to_leg(1'b1, src);
				end
			end else if (host_sel[ch]) begin
				tgt = to_leg(serial_drive[i], serial_level[i]);
			end else if (chop_active[ch]) begin
				// Chopping recirculates through the low side.
				tgt = LEG_LO;
			end else begin
				// Each leg follows its input; equal inputs brake.
				tgt = to_leg(1'b1, src);
			end

			// A leg turns off at once; only a direct swap from one level to the other
			// goes through the off state and waits out the dead time before driving again.
			if (st_q.dead[i] != '0) begin
				st_d.dead[i] = st_q.dead[i] - 1'b1;
			end else if (tgt != st_q.leg[i]) begin
				if (st_q.leg[i] != LEG_OFF && tgt != LEG_OFF) begin
					st_d.leg[i] = LEG_OFF;
					st_d.dead[i] = DEAD_W'(DEAD_CYC - 1);
				end else begin
					st_d.leg[i] = tgt;
				end
			end
			// During a countdown a request to turn off still acts.
			if (tgt == LEG_OFF) begin
				st_d.leg[i] = LEG_OFF;
			end
			st_d.oe[i] = (st_d.leg[i] != LEG_OFF);
			st_d.lvl[i] = (st_d.leg[i] == LEG_HI);
		end

		// Dropping the logic supply is the only way out of a latched
		// configuration, prohibited included.
		// It also clears the dead-time counters, so no countdown outlives it.
		if (!pins.supply_on) begin
			st_d = DEV_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers.

	// The whole state is one record, so every output is a flop.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= DEV_RST;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	// Pin outputs come straight from the state record.
	// An off leg also shows level low, so a stale high never sits behind a
	// released pin.
	assign pins.bridge_out_a = st_q.lvl[0];
	assign pins.bridge_out_b = st_q.lvl[1];
	assign pins.bridge_out_c = st_q.lvl[2];
	assign pins.bridge_out_d = st_q.lvl[3];
	assign pins.bridge_oe_a = st_q.oe[0];
	assign pins.bridge_oe_b = st_q.oe[1];
	assign pins.bridge_oe_c = st_q.oe[2];
	assign pins.bridge_oe_d = st_q.oe[3];
	assign cfg_latched = st_q.cfg_valid;
	assign cfg_mode = st_q.mode;

endmodule : hbd_device

// ==== core/hbd_host.sv ====
module hbd_host
	import hbd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	hbd_if.host pins,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// True when going from one pwm pair to the other reverses the motor.
	function automatic logic is_reversal(input logic [1:0] a,
		input logic [1:0] b);
		return (a == 2'b01 && b == 2'b10) || (a == 2'b10 && b == 2'b01);
	endfunction : is_reversal

	hbd_host_st_t st_q;
	hbd_host_st_t st_d;

	////////////////////////////////////////////////////////////////////////
	// Next state.

	// Register writes, brake sequencing and pin levels.
	always_comb begin
		logic combined;
		logic half;
		logic [1:0] req;
		logic [31:0] stat;
		combined = 1'b0;
		half = 1'b0;
		req = '0;
		stat = '0;
		st_d = st_q;
		st_d.diag = 1'b0;
		st_d.rdata = '0;

		if (reg_wr && reg_addr == REG_CTRL) begin
			st_d.ctrl = reg_wdata[CTRL_W-1:0];
			// Pulse bits act on the write and are not stored.
			st_d.ctrl[CTRL_DIAG] = 1'b0;
			st_d.ctrl[CTRL_PWR] = 1'b0;
			st_d.diag = reg_wdata[CTRL_DIAG];
		end
		if (reg_wr && reg_addr == REG_PWM) begin
			st_d.drv = reg_wdata[PWMR_W-1:0];
		end

		// Restart by holding the logic supply off for a while.
		if (st_q.pwr_cnt != '0) begin
			st_d.pwr_cnt = st_q.pwr_cnt - 1'b1;
		end
		if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_PWR]) begin
			st_d.pwr_cnt = PWR_W'(PWR_OFF_CYC);
		end

		combined = !st_d.ctrl[CTRL_CFG_A] && !st_d.ctrl[CTRL_CFG_B];
		half = st_d.ctrl[CTRL_CFG_A] && !st_d.ctrl[CTRL_CFG_B];

		// A reversal passes through a full brake time first.
		for (int c = 0; c < 2; c++) begin
			req = st_q.drv[PWM_REQ_LSB + 2 * c +: 2];
			if (st_q.brake[c] != '0) begin
				st_d.brake[c] = st_q.brake[c] - 1'b1;
			end else if (is_reversal(st_q.pwm_app[2 * c +: 2], req)) begin
				st_d.pwm_app[2 * c +: 2] = 2'b00;
				st_d.brake[c] = BRAKE_W'(BRAKE_CYC - 1);
			end else begin
				st_d.pwm_app[2 * c +: 2] = req;
			end
		end

		st_d.pwm_oe = ~st_d.drv[PWM_FLT_LSB +: 4];
		st_d.en_lvl[0] = st_d.ctrl[CTRL_EN1];
		st_d.en_oe[0] = ~st_d.drv[EN_FLT_LSB];
		st_d.inh_lvl[0] = st_d.ctrl[CTRL_INH1];
		st_d.sleep_n = st_d.ctrl[CTRL_SLEEP_N];
		// Inhibits never float while sleep is requested.
		st_d.inh_oe[0] = ~st_d.drv[INH_FLT_LSB] | ~st_d.sleep_n;
		// Half mode keeps the first host select low.
		st_d.host_sel[0] = half ? 1'b0 : st_d.ctrl[CTRL_HS1];
		// Combined mode ties the second channel's pins to the first.
		if (combined) begin
			st_d.en_lvl[1] = st_d.en_lvl[0];
			st_d.en_oe[1] = st_d.en_oe[0];
			st_d.inh_lvl[1] = st_d.inh_lvl[0];
			st_d.inh_oe[1] = st_d.inh_oe[0];
			st_d.host_sel[1] = st_d.host_sel[0];
		end else begin
			st_d.en_lvl[1] = st_d.ctrl[CTRL_EN2];
			st_d.en_oe[1] = ~st_d.drv[EN_FLT_LSB + 1];
			st_d.inh_lvl[1] = st_d.ctrl[CTRL_INH2];
			st_d.inh_oe[1] = ~st_d.drv[INH_FLT_LSB + 1] | ~st_d.sleep_n;
			st_d.host_sel[1] = st_d.ctrl[CTRL_HS2];
		end
		st_d.cfg_a = st_d.ctrl[CTRL_CFG_A];
		st_d.cfg_b = st_d.ctrl[CTRL_CFG_B];
		st_d.supply_on = (st_d.pwr_cnt == '0);

		// Status shows the driver's legs as seen on the pins.
		stat[STAT_LVL_LSB +: 4] = {pins.bridge_out_d, pins.bridge_out_c,
			pins.bridge_out_b, pins.bridge_out_a};
		stat[STAT_OE_LSB +: 4] = {pins.bridge_oe_d, pins.bridge_oe_c,
			pins.bridge_oe_b, pins.bridge_oe_a};
		stat[STAT_PWR_OFF] = !st_q.supply_on;
		stat[STAT_BRK_LSB] = (st_q.brake[0] != '0);
		stat[STAT_BRK_LSB + 1] = (st_q.brake[1] != '0);
		// Read data stand for the one cycle after the strobe only.
		if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL: st_d.rdata = 32'(st_q.ctrl);
				REG_PWM: st_d.rdata = 32'(st_q.drv);
				REG_STAT: st_d.rdata = stat;
				default: st_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and outputs.

	// Reset keeps the supply off until the first clocked cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= HOST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign pins.pwm_in_a = st_q.pwm_app[0];
	assign pins.pwm_in_b = st_q.pwm_app[1];
	assign pins.pwm_in_c = st_q.pwm_app[2];
	assign pins.pwm_in_d = st_q.pwm_app[3];
	assign pins.pwm_oe_a = st_q.pwm_oe[0];
	assign pins.pwm_oe_b = st_q.pwm_oe[1];
	assign pins.pwm_oe_c = st_q.pwm_oe[2];
	assign pins.pwm_oe_d = st_q.pwm_oe[3];
	assign pins.drive_enable_first = st_q.en_lvl[0];
	assign pins.drive_enable_second = st_q.en_lvl[1];
	assign pins.drive_enable_first_oe = st_q.en_oe[0];
	assign pins.drive_enable_second_oe = st_q.en_oe[1];
	assign pins.channel_inhibit_first = st_q.inh_lvl[0];
	assign pins.channel_inhibit_second = st_q.inh_lvl[1];
	assign pins.channel_inhibit_first_oe = st_q.inh_oe[0];
	assign pins.channel_inhibit_second_oe = st_q.inh_oe[1];
	assign pins.low_power_request_n = st_q.sleep_n;
	assign pins.bridge_config_sel_a = st_q.cfg_a;
	assign pins.bridge_config_sel_b = st_q.cfg_b;
	assign pins.host_select_first = st_q.host_sel[0];
	assign pins.host_select_second = st_q.host_sel[1];
	assign pins.supply_on = st_q.supply_on;
	assign pins.diag_start = st_q.diag;

endmodule : hbd_host

// ==== dv/hbd_asserts.sv ====
// Watches the pins between controller and bridge driver.
module hbd_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic pwm_in_a,
	input wire logic pwm_in_b,
	input wire logic pwm_in_c,
	input wire logic pwm_in_d,
	input wire logic pwm_oe_a,
	input wire logic drive_enable_first,
	input wire logic drive_enable_first_oe,
	input wire logic channel_inhibit_first,
	input wire logic channel_inhibit_first_oe,
	input wire logic low_power_request_n,
	input wire logic supply_on,
	input wire logic bridge_out_a,
	input wire logic bridge_out_b,
	input wire logic bridge_out_c,
	input wire logic bridge_out_d,
	input wire logic bridge_oe_a,
	input wire logic bridge_oe_b,
	input wire logic bridge_oe_c,
	input wire logic bridge_oe_d
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] oe;
	logic [3:0] lvl;

	////////////////////////////////////////////////////////////////////////
	// Legs packed d..a so one check covers all four at once.
	assign oe = {bridge_oe_d, bridge_oe_c, bridge_oe_b, bridge_oe_a};
	assign lvl = {bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a};

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	// Repetitions of three or four leave room for the pin-to-leg latency.
	property p_sleep;
		(!low_power_request_n)[*3] |-> oe == 4'h0;
	endproperty
	property p_supply;
		!supply_on |=> oe == 4'h0;
	endproperty
	property p_en_low;
		(drive_enable_first_oe && !drive_enable_first)[*3] |-> oe[1:0] == 0;
	endproperty
	property p_en_float;
		(!drive_enable_first_oe)[*3] |-> oe[1:0] == 2'h0;
	endproperty
	property p_inh;
		(channel_inhibit_first || !channel_inhibit_first_oe)[*3]
			|-> oe[1:0] == 2'h0;
	endproperty
	// A leg may never swap level while it keeps driving: shoot-through.
	property p_dead;
		(oe & $past(oe) & (lvl ^ $past(lvl))) == 4'h0;
	endproperty
	property p_brake_ab;
		(pwm_in_a ^ pwm_in_b) |=> !(pwm_in_a ^ pwm_in_b) || $stable(pwm_in_a);
	endproperty
	property p_brake_cd;
		(pwm_in_c ^ pwm_in_d) |=> !(pwm_in_c ^ pwm_in_d) || $stable(pwm_in_c);
	endproperty
	property p_pwm_hi;
		(pwm_in_a && pwm_oe_a)[*4] ##0 bridge_oe_a |-> bridge_out_a;
	endproperty
	property p_pwm_flt;
		(!pwm_oe_a)[*4] ##0 bridge_oe_a |-> !bridge_out_a;
	endproperty

	a_sleep: assert property (p_sleep)
		else $error("leg driven during sleep");
	a_supply: assert property (p_supply)
		else $error("leg driven with supply off");
	a_en_low: assert property (p_en_low)
		else $error("first pair driven with enable low");
	a_en_float: assert property (p_en_float)
		else $error("first pair driven with enable floating");
	a_inh: assert property (p_inh)
		else $error("first pair driven while inhibited");
	a_dead: assert property (p_dead)
		else $error("leg swapped level without off time");
	a_brake_ab: assert property (p_brake_ab)
		else $error("first pair reversed without brake");
	a_brake_cd: assert property (p_brake_cd)
		else $error("second pair reversed without brake");
	a_pwm_hi: assert property (p_pwm_hi)
		else $error("leg a low while its input is high");
	a_pwm_flt: assert property (p_pwm_flt)
		else $error("leg a high while its input floats");

	c_sleep: cover property ((!low_power_request_n)[*3]);
	c_fwd: cover property (oe == 4'hF && lvl == 4'h9);
	c_flt: cover property ((!pwm_oe_a)[*4] ##0 bridge_oe_a);
endmodule : hbd_asserts

// ==== dv/hbd_tb.sv ====
module testbench
	import hbd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk;
	logic rst;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic reg_wr;
	logic reg_rd;
	logic cfg_latched;
	hbd_mode_t cfg_mode;
	logic [3:0] oe_v;
	logic [3:0] lvl_v;
	logic [1:0] inh_oe_v;
	logic [3:0] serial_level;
	logic [3:0] serial_drive;
	logic [1:0] chop_active;
	int failures = 0;
	int compares = 0;
	int cycles = 0;

	////////////////////////////////////////////////////////////////////////
	// Both ends face each other; the bench plays serial path and chopping.
	hbd_if bus ();
	hbd_host i_hbd_host (.clk(clk), .rst(rst), .pins(bus.host),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	hbd_device i_hbd_device (.clk(clk), .rst(rst), .pins(bus.dev),
		.serial_level(serial_level), .serial_drive(serial_drive),
		.chop_active(chop_active),
		.cfg_latched(cfg_latched), .cfg_mode(cfg_mode));
	hbd_asserts i_hbd_asserts (.clk(clk), .rst(rst),
		.pwm_in_a(bus.pwm_in_a), .pwm_in_b(bus.pwm_in_b),
		.pwm_in_c(bus.pwm_in_c), .pwm_in_d(bus.pwm_in_d),
		.pwm_oe_a(bus.pwm_oe_a),
		.drive_enable_first(bus.drive_enable_first),
		.drive_enable_first_oe(bus.drive_enable_first_oe),
		.channel_inhibit_first(bus.channel_inhibit_first),
		.channel_inhibit_first_oe(bus.channel_inhibit_first_oe),
		.low_power_request_n(bus.low_power_request_n),
		.supply_on(bus.supply_on),
		.bridge_out_a(bus.bridge_out_a), .bridge_out_b(bus.bridge_out_b),
		.bridge_out_c(bus.bridge_out_c), .bridge_out_d(bus.bridge_out_d),
		.bridge_oe_a(bus.bridge_oe_a), .bridge_oe_b(bus.bridge_oe_b),
		.bridge_oe_c(bus.bridge_oe_c), .bridge_oe_d(bus.bridge_oe_d));

	// Legs packed d..a to match the expected nibbles.
	assign oe_v = {bus.bridge_oe_d, bus.bridge_oe_c, bus.bridge_oe_b,
		bus.bridge_oe_a};
	assign lvl_v = {bus.bridge_out_d, bus.bridge_out_c, bus.bridge_out_b,
		bus.bridge_out_a};
	assign inh_oe_v = {bus.channel_inhibit_second_oe,
		bus.channel_inhibit_first_oe};

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard; a full run takes about 3700 cycles.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			failures++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared tasks.
	task automatic complete_run();
		if (failures == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic cmp_v(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : cmp_v

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input string what);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		cmp_v(what, exp, reg_rdata);
	endtask : rd

	// 150 cycles cover the 100-cycle brake plus the 20-cycle off time.
	task automatic legs(input string what, input logic [3:0] l,
		input logic [3:0] e);
		repeat (150) @(posedge clk);
		#1;
		cmp_v({what, " oe"}, {28'h0, e}, {28'h0, oe_v});
		cmp_v({what, " lvl"}, {28'h0, l & e}, {28'h0, lvl_v & oe_v});
	endtask : legs

	// Power cycle, set the straps, then start the diagnosis.
	task automatic mode_up(input logic [31:0] c, input hbd_mode_t m);
		wr(REG_CTRL, c | 32'h0000_0010);
		repeat (120) @(posedge clk);
		wr(REG_CTRL, c);
		wr(REG_CTRL, c | 32'h0000_0008);
		repeat (4) @(posedge clk);
		#1;
		cmp_v("latched", 32'h0000_0001, {31'h0, cfg_latched});
		cmp_v("mode", {30'h0, m}, {30'h0, cfg_mode});
	endtask : mode_up

	////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic run_dual();
		mode_up(32'h0000_0066, MODE_DUAL);
		wr(REG_PWM, 32'h0000_0000);
		legs("brake low", 4'h0, 4'hF);
		wr(REG_PWM, 32'h0000_0009);
		legs("forward", 4'h9, 4'hF);
		rd(REG_STAT, 32'h0000_00F9, "status");
		wr(REG_CTRL, 32'h0000_0466);
		serial_drive <= 4'h4;
		serial_level <= 4'h4;
		legs("serial", 4'h5, 4'h7);
		wr(REG_CTRL, 32'h0000_0066);
		serial_drive <= 4'h0;
		chop_active <= 2'h2;
		legs("chop", 4'h1, 4'hF);
		wr(REG_PWM, 32'h0000_0006);
		chop_active <= 2'h0;
		legs("reverse", 4'h6, 4'hF);
		wr(REG_PWM, 32'h0000_000F);
		legs("brake high", 4'hF, 4'hF);
		wr(REG_PWM, 32'h0000_0013);
		legs("pwm float", 4'h2, 4'hF);
		wr(REG_PWM, 32'h0000_0109);
		legs("en1 float", 4'h9, 4'hC);
		wr(REG_PWM, 32'h0000_0809);
		legs("inh2 float", 4'h9, 4'h3);
		wr(REG_PWM, 32'h0000_0009);
		wr(REG_CTRL, 32'h0000_0026);
		legs("en2 low", 4'h9, 4'h3);
		wr(REG_CTRL, 32'h0000_00E6);
		legs("inh1 high", 4'h9, 4'hC);
		wr(REG_CTRL, 32'h0000_0062);
		wr(REG_PWM, 32'h0000_0C09);
		legs("sleep", 4'h9, 4'h0);
		cmp_v("inh oe", 32'h0000_0003, {30'h0, inh_oe_v});
		wr(REG_PWM, 32'h0000_0009);
		// Straps now say half mode; a later diagnosis must not take them.
		wr(REG_CTRL, 32'h0000_0065);
		legs("wake", 4'h9, 4'hF);
		wr(REG_CTRL, 32'h0000_006D);
		repeat (4) @(posedge clk);
		#1;
		cmp_v("mode kept", {30'h0, MODE_DUAL}, {30'h0, cfg_mode});
		rd(REG_CTRL, 32'h0000_0065, "ctrl");
		rd(8'h0C, 32'h0000_0000, "unmapped");
	endtask : run_dual

	task automatic run_prohib();
		mode_up(32'h0000_0067, MODE_PROHIBITED);
		legs("prohibited", 4'h0, 4'h0);
		wr(REG_CTRL, 32'h0000_0066);
		wr(REG_CTRL, 32'h0000_006E);
		legs("stuck", 4'h0, 4'h0);
		cmp_v("stuck mode", {30'h0, MODE_PROHIBITED}, {30'h0, cfg_mode});
	endtask : run_prohib

	task automatic run_comb();
		mode_up(32'h0000_0064, MODE_COMBINED);
		wr(REG_PWM, 32'h0000_0005);
		legs("combined fwd", 4'h3, 4'hF);
		wr(REG_PWM, 32'h0000_0002);
		legs("combined rev", 4'hC, 4'hF);
	endtask : run_comb

	task automatic run_half();
		mode_up(32'h0000_0065, MODE_HALF);
		wr(REG_PWM, 32'h0000_0006);
		legs("half", 4'h6, 4'hF);
		// The host holds the first select low; the serial path is offered.
		wr(REG_CTRL, 32'h0000_0665);
		serial_drive <= 4'hF;
		legs("half pins", 4'h6, 4'hF);
		cmp_v("hs1", 32'h0000_0000, {31'h0, bus.host_select_first});
		// Straps that look combined let the host raise the first select.
		wr(REG_CTRL, 32'h0000_0264);
		legs("half host", 4'h6, 4'h0);
		wr(REG_CTRL, 32'h0000_0065);
		legs("half back", 4'h6, 4'hF);
	endtask : run_half

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		serial_level = 4'h0;
		serial_drive = 4'h0;
		chop_active = 2'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		run_dual();
		run_prohib();
		run_comb();
		run_half();
		complete_run();
	end
endmodule : testbench
